// file: nbc_pkg.sv
// Shared types, command codes and timing constants of the NAND bus host controller
package nbc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_WR_LOW_NS = 24;
    localparam int T_WR_HIGH_NS = 16;
    localparam int T_RD_LOW_NS = 40;
    localparam int T_RD_HIGH_NS = 16;
    localparam int T_BUSY_SETTLE_NS = 100;
    localparam int T_RECOVERY_NS = 10000;
    localparam int TMR_W = 12;
    // Least times, rounded up to whole cycles
    localparam logic [TMR_W-1:0] WR_LOW_CYC = TMR_W'((T_WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] WR_HIGH_CYC = TMR_W'((T_WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] RD_LOW_CYC = TMR_W'((T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] RD_HIGH_CYC = TMR_W'((T_RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] BUSY_SETTLE_CYC = TMR_W'((T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] RECOVERY_CYC = TMR_W'((T_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_GO = 8'h30;
    localparam logic [7:0] CMD_CACHE_GO = 8'h31;
    localparam logic [7:0] CMD_EXIT_CACHE = 8'h34;
    localparam logic [7:0] CMD_COPY_GO = 8'h35;
    localparam logic [7:0] CMD_RAND_OUT = 8'h05;
    localparam logic [7:0] CMD_RAND_OUT_GO = 8'he0;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_CACHE_PROG_GO = 8'h15;
    localparam logic [7:0] CMD_RAND_IN = 8'h85;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_SIGNATURE = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_LOCK_STATUS = 8'h7a;
    localparam logic [7:0] CMD_UNLOCK = 8'h23;
    localparam logic [7:0] CMD_UNLOCK_GO = 8'h24;
    localparam logic [7:0] CMD_LOCK = 8'h2a;
    localparam logic [7:0] CMD_LOCK_DOWN = 8'h2c;

    // ****************************************
    // Address layout
    // ****************************************
    localparam int COL_W = 12;
    localparam int PAGE_W = 6;
    localparam int BLOCK_W = 13;
    localparam int LEN_W = 12;
    localparam logic [2:0] ADDR_FULL = 3'h5;
    localparam logic [2:0] ADDR_COL = 3'h2;
    localparam logic [2:0] ADDR_ROW = 3'h3;
    localparam logic [2:0] ADDR_SIG = 3'h1;
    localparam logic [2:0] ROW_START = 3'h2;

    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_CACHE_READ = 4'h1, OP_EXIT_CACHE = 4'h2, OP_RAND_OUT = 4'h3,
        OP_PROGRAM = 4'h4, OP_CACHE_PROG = 4'h5, OP_RAND_IN = 4'h6, OP_COPY_SRC = 4'h7,
        OP_COPY_DST = 4'h8, OP_ERASE = 4'h9, OP_RESET = 4'ha, OP_SIGNATURE = 4'hb,
        OP_STATUS = 4'hc, OP_LOCK_STATUS = 4'hd, OP_UNLOCK = 4'he, OP_LOCK = 4'hf
    } nbc_op_type;

    typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_WRITE = 2'h1, DIR_READ = 2'h2} nbc_dir_type;

    // User request
    typedef struct packed {
        nbc_op_type op;
        logic lock_down;
        logic [COL_W-1:0] column;
        logic [PAGE_W-1:0] page;
        logic [BLOCK_W-1:0] block;
        logic [LEN_W-1:0] len;
    } nbc_req_type;

    // Per-operation sequence profile
    typedef struct packed {
        logic [7:0] cmd1;
        logic [2:0] naddr;
        logic [2:0] astart;
        nbc_dir_type dir;
        logic has_cmd2;
        logic [7:0] cmd2;
        logic wait_busy;
        logic writes_array;
        logic busy_ok;
    } nbc_prof_type;

    // Pins driven toward the memory
    typedef struct packed {
        logic chip_sel_n;
        logic command_latch_enable;
        logic addr_latch_enable;
        logic wr_strobe_n;
        logic rd_strobe_n;
        logic wp_n;
        logic [7:0] bus_out;
        logic bus_oe_n;
    } nbc_pins_type;

    localparam nbc_pins_type PINS_IDLE = '{chip_sel_n: 1'b1, command_latch_enable: 1'b0,
        addr_latch_enable: 1'b0, wr_strobe_n: 1'b1, rd_strobe_n: 1'b1, wp_n: 1'b0,
        bus_out: 8'h00, bus_oe_n: 1'b1};

    // Sequence profile of each operation
    function automatic nbc_prof_type op_profile(input nbc_req_type r);
        nbc_prof_type p;
        p = '{cmd1: CMD_READ, naddr: ADDR_FULL, astart: 3'h0, dir: DIR_READ, has_cmd2: 1'b1,
              cmd2: CMD_READ_GO, wait_busy: 1'b1, writes_array: 1'b0, busy_ok: 1'b0};
        case (r.op)
            OP_CACHE_READ: p.cmd2 = CMD_CACHE_GO;
            OP_EXIT_CACHE: begin
                p.cmd1 = CMD_EXIT_CACHE; p.naddr = 3'h0; p.has_cmd2 = 1'b0; p.wait_busy = 1'b0;
                p.busy_ok = 1'b1;
            end
            OP_RAND_OUT: begin
                p.cmd1 = CMD_RAND_OUT; p.naddr = ADDR_COL; p.cmd2 = CMD_RAND_OUT_GO; p.wait_busy = 1'b0;
            end
            OP_PROGRAM, OP_CACHE_PROG: begin
                p.cmd1 = CMD_PROG; p.dir = DIR_WRITE; p.writes_array = 1'b1;
                p.cmd2 = (r.op == OP_PROGRAM) ? CMD_PROG_GO : CMD_CACHE_PROG_GO;
            end
            OP_RAND_IN: begin
                p.cmd1 = CMD_RAND_IN; p.naddr = ADDR_COL; p.dir = DIR_WRITE; p.has_cmd2 = 1'b0;
                p.wait_busy = 1'b0; p.writes_array = 1'b1;
            end
            OP_COPY_SRC: begin
                p.dir = DIR_NONE; p.cmd2 = CMD_COPY_GO;
            end
            OP_COPY_DST: begin
                p.cmd1 = CMD_RAND_IN; p.dir = DIR_WRITE; p.cmd2 = CMD_PROG_GO; p.writes_array = 1'b1;
            end
            OP_ERASE: begin
                p.cmd1 = CMD_ERASE; p.naddr = ADDR_ROW; p.astart = ROW_START; p.dir = DIR_NONE;
                p.cmd2 = CMD_ERASE_GO; p.writes_array = 1'b1;
            end
            OP_RESET: begin
                p.cmd1 = CMD_RESET; p.naddr = 3'h0; p.dir = DIR_NONE; p.has_cmd2 = 1'b0; p.busy_ok = 1'b1;
            end
            OP_SIGNATURE: begin
                p.cmd1 = CMD_SIGNATURE; p.naddr = ADDR_SIG; p.has_cmd2 = 1'b0; p.wait_busy = 1'b0;
            end
            OP_STATUS: begin
                p.cmd1 = CMD_STATUS; p.naddr = 3'h0; p.has_cmd2 = 1'b0; p.wait_busy = 1'b0; p.busy_ok = 1'b1;
            end
            OP_LOCK_STATUS: begin
                p.cmd1 = CMD_LOCK_STATUS; p.naddr = ADDR_ROW; p.astart = ROW_START; p.has_cmd2 = 1'b0;
                p.wait_busy = 1'b0;
            end
            OP_UNLOCK: begin
                p.cmd1 = CMD_UNLOCK; p.naddr = ADDR_ROW; p.astart = ROW_START; p.dir = DIR_NONE;
                p.cmd2 = CMD_UNLOCK_GO; p.wait_busy = 1'b0;
            end
            OP_LOCK: begin
                p.cmd1 = r.lock_down ? CMD_LOCK_DOWN : CMD_LOCK; p.naddr = 3'h0; p.dir = DIR_NONE;
                p.has_cmd2 = 1'b0; p.wait_busy = 1'b0;
            end
            default: p.cmd1 = CMD_READ;
        endcase
        return p;
    endfunction

endpackage

// file: nbc_timer.sv
// Down-counting interval timer giving a one-cycle done pulse
`timescale 1ns/1ps
module nbc_timer
    import nbc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [TMR_W-1:0] load_val,
    output logic done
);

    logic [TMR_W-1:0] count_r;
    logic [TMR_W-1:0] count_nxt;
    logic done_r;
    logic done_nxt;

    // Count down from the loaded value, pulse done at the end
    always_comb begin
        count_nxt = count_r;
        done_nxt = 1'b0;
        if (load) begin
            count_nxt = load_val;
        end else if (count_r != '0) begin
            count_nxt = count_r - TMR_W'(1);
            done_nxt = (count_r == TMR_W'(1));
        end
    end

    // Timer registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            done_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;

endmodule // nbc_timer

// file: nbc_host.sv
// Host-side sequencer driving the NAND flash strobes, bus and write protect
`timescale 1ns/1ps
// Function
// - Release the byte bus while reading; reads only with strobes and latches set.
// - Pulse read strobe low once per output byte; device supplies next byte.
// - Hold write protect high whenever a program or erase code is issued.
// - Page read is 00h, five address cycles, then 30h.
// - Page program is 80h, address, data, then 10h.
// - Block erase is 60h, block address cycles, then D0h.
// - Copy-back is 00h, source address, 35h, 85h, target address, 10h.
// - Command cycle: chip select low, command latch high, address latch low, read high.
// - Address given as one to five byte cycles with address latch high, command latch low.
module nbc_host
    import nbc_pkg::*;
#(
    parameter bit TWO_DIE = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire nbc_req_type req,
    output logic req_ready,
    input wire logic [7:0] wdata,
    input wire logic wdata_valid,
    output logic wdata_take,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic op_done,
    output logic cache_active,
    output nbc_pins_type pins,
    input wire logic [7:0] bus_in,
    input wire logic busy_flag_n
);

    // ****************************************
    // States and registers
    // ****************************************
    typedef enum logic [10:0] {
        ST_POWER = 11'h001, ST_IDLE = 11'h002, ST_WAIT_READY = 11'h004, ST_CMD1 = 11'h008,
        ST_ADDR = 11'h010, ST_WDATA = 11'h020, ST_CMD2 = 11'h040, ST_SETTLE = 11'h080,
        ST_BUSY = 11'h100, ST_RDATA = 11'h200, ST_DONE = 11'h400
    } nbc_state_type;

    nbc_state_type state_r, state_nxt;
    nbc_req_type req_r, req_nxt;
    nbc_prof_type prof_r, prof_nxt;
    nbc_pins_type pins_r, pins_nxt;
    logic sub_r, sub_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [LEN_W-1:0] cnt_r, cnt_nxt;
    logic req_ready_r, req_ready_nxt;
    logic wdata_take_r, wdata_take_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rdata_valid_r, rdata_valid_nxt;
    logic op_done_r, op_done_nxt;
    logic cache_r, cache_nxt;
    logic [7:0] bus_m_r, bus_s_r;
    logic busy_m_r, busy_s_r;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_done;
    logic strobe_low;

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_m_r <= 8'h00;
            bus_s_r <= 8'h00;
            busy_m_r <= 1'b0;
            busy_s_r <= 1'b0;
        end else begin
            bus_m_r <= bus_in;
            bus_s_r <= bus_m_r;
            busy_m_r <= busy_flag_n;
            busy_s_r <= busy_m_r;
        end
    end

    nbc_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // Address byte for cycle i, low byte first
    function automatic logic [7:0] addr_byte(input nbc_req_type r, input logic [2:0] i);
        case (i)
            3'h0: addr_byte = r.column[7:0];
            3'h1: addr_byte = {4'h0, r.column[11:8]};
            3'h2: addr_byte = {r.block[1:0], r.page};
            3'h3: addr_byte = r.block[9:2];
            3'h4: addr_byte = {5'h00, TWO_DIE & r.block[12], r.block[11:10]};
            default: addr_byte = 8'h00;
        endcase
    endfunction

    assign strobe_low = !pins_r.wr_strobe_n || !pins_r.rd_strobe_n;

    // ****************************************
    // Sequencer next state
    // ****************************************
    always_comb begin
        nbc_state_type after_addr;
        nbc_state_type after_cmd2;
        nbc_prof_type new_prof;
        new_prof = op_profile(req);
        after_cmd2 = prof_r.wait_busy ? ST_SETTLE
                   : ((prof_r.dir == DIR_READ && req_r.len != '0) ? ST_RDATA : ST_DONE);
        after_addr = (prof_r.dir == DIR_WRITE && req_r.len != '0) ? ST_WDATA
                   : (prof_r.has_cmd2 ? ST_CMD2 : after_cmd2);
        state_nxt = state_r;
        req_nxt = req_r;
        prof_nxt = prof_r;
        pins_nxt = pins_r;
        sub_nxt = sub_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        req_ready_nxt = req_ready_r;
        wdata_take_nxt = 1'b0;
        rdata_nxt = rdata_r;
        rdata_valid_nxt = 1'b0;
        op_done_nxt = 1'b0;
        cache_nxt = cache_r;
        tmr_load = 1'b0;
        tmr_val = WR_LOW_CYC;
        // Second half of every bus cycle: raise strobe, then wait high time
        if (sub_r && tmr_done && strobe_low) begin
            tmr_load = 1'b1;
            tmr_val = pins_r.rd_strobe_n ? WR_HIGH_CYC : RD_HIGH_CYC;
            if (!pins_r.rd_strobe_n) begin
                rdata_nxt = bus_s_r;
                rdata_valid_nxt = 1'b1;
            end
            pins_nxt.wr_strobe_n = 1'b1;
            pins_nxt.rd_strobe_n = 1'b1;
        end
        case (state_r)
            ST_POWER: begin
                if (!sub_r) begin
                    tmr_load = 1'b1;
                    tmr_val = RECOVERY_CYC;
                    sub_nxt = 1'b1;
                end else if (tmr_done) begin
                    sub_nxt = 1'b0;
                    req_ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                pins_nxt = PINS_IDLE;
                if (req_valid) begin
                    req_nxt = req;
                    prof_nxt = new_prof;
                    req_ready_nxt = 1'b0;
                    pins_nxt.chip_sel_n = 1'b0;
                    pins_nxt.wp_n = new_prof.writes_array;
                    idx_nxt = new_prof.astart;
                    cnt_nxt = '0;
                    if (new_prof.busy_ok && (req.op != OP_EXIT_CACHE || cache_r)) begin
                        state_nxt = ST_CMD1;
                    end else begin
                        state_nxt = ST_WAIT_READY;
                    end
                end
            end
            ST_WAIT_READY: begin
                if (busy_s_r) begin
                    state_nxt = ST_CMD1;
                end
            end
            ST_CMD1, ST_CMD2, ST_ADDR, ST_WDATA, ST_RDATA: begin
                if (!sub_r && (state_r != ST_WDATA || wdata_valid)) begin
                    // First half: set latches and bus, drop a strobe
                    sub_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = (state_r == ST_RDATA) ? RD_LOW_CYC : WR_LOW_CYC;
                    pins_nxt.command_latch_enable = (state_r == ST_CMD1 || state_r == ST_CMD2);
                    pins_nxt.addr_latch_enable = (state_r == ST_ADDR);
                    pins_nxt.bus_oe_n = (state_r == ST_RDATA);
                    pins_nxt.wr_strobe_n = (state_r == ST_RDATA);
                    pins_nxt.rd_strobe_n = (state_r != ST_RDATA);
                    case (state_r)
                        ST_CMD1: pins_nxt.bus_out = prof_r.cmd1;
                        ST_CMD2: pins_nxt.bus_out = prof_r.cmd2;
                        ST_ADDR: pins_nxt.bus_out = addr_byte(req_r, idx_r);
                        ST_WDATA: pins_nxt.bus_out = wdata;
                        default: pins_nxt.bus_out = pins_r.bus_out;
                    endcase
                    wdata_take_nxt = (state_r == ST_WDATA);
                end else if (sub_r && tmr_done && !strobe_low) begin
                    // Cycle finished: pick the next step
                    sub_nxt = 1'b0;
                    case (state_r)
                        ST_CMD1: state_nxt = (prof_r.naddr != 3'h0) ? ST_ADDR : after_addr;
                        ST_ADDR: begin
                            idx_nxt = idx_r + 3'h1;
                            if (idx_r + 3'h1 == prof_r.astart + prof_r.naddr) begin
                                state_nxt = after_addr;
                            end
                        end
                        ST_WDATA: begin
                            cnt_nxt = cnt_r + LEN_W'(1);
                            if (cnt_r + LEN_W'(1) == req_r.len) begin
                                state_nxt = prof_r.has_cmd2 ? ST_CMD2 : ST_DONE;
                            end
                        end
                        ST_CMD2: state_nxt = after_cmd2;
                        default: begin
                            cnt_nxt = cnt_r + LEN_W'(1);
                            if (cnt_r + LEN_W'(1) == req_r.len) begin
                                state_nxt = ST_DONE;
                            end
                        end
                    endcase
                end
            end
            ST_SETTLE: begin
                pins_nxt.command_latch_enable = 1'b0;
                if (!sub_r) begin
                    tmr_load = 1'b1;
                    tmr_val = BUSY_SETTLE_CYC;
                    sub_nxt = 1'b1;
                end else if (tmr_done) begin
                    sub_nxt = 1'b0;
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (busy_s_r) begin
                    state_nxt = (prof_r.dir == DIR_READ && req_r.len != '0) ? ST_RDATA : ST_DONE;
                end
            end
            ST_DONE: begin
                pins_nxt = PINS_IDLE;
                op_done_nxt = 1'b1;
                req_ready_nxt = 1'b1;
                if (req_r.op == OP_CACHE_READ) begin
                    cache_nxt = 1'b1;
                end else if (req_r.op == OP_EXIT_CACHE || req_r.op == OP_RESET) begin
                    cache_nxt = 1'b0;
                end
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_POWER;
            req_r <= '0;
            prof_r <= '0;
            pins_r <= PINS_IDLE;
            sub_r <= 1'b0;
            idx_r <= 3'h0;
            cnt_r <= '0;
            req_ready_r <= 1'b0;
            wdata_take_r <= 1'b0;
            rdata_r <= 8'h00;
            rdata_valid_r <= 1'b0;
            op_done_r <= 1'b0;
            cache_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            prof_r <= prof_nxt;
            pins_r <= pins_nxt;
            sub_r <= sub_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            req_ready_r <= req_ready_nxt;
            wdata_take_r <= wdata_take_nxt;
            rdata_r <= rdata_nxt;
            rdata_valid_r <= rdata_valid_nxt;
            op_done_r <= op_done_nxt;
            cache_r <= cache_nxt;
        end
    end

    assign req_ready = req_ready_r;
    assign wdata_take = wdata_take_r;
    assign rdata = rdata_r;
    assign rdata_valid = rdata_valid_r;
    assign op_done = op_done_r;
    assign cache_active = cache_r;
    assign pins = pins_r;

endmodule // nbc_host

// file: nbc_host_monitor.sv
// Pin protocol checker bound to the NAND host controller
`timescale 1ns/1ps
module nbc_host_monitor
    import nbc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire nbc_req_type req,
    input wire logic req_ready,
    input wire logic [7:0] wdata,
    input wire logic wdata_valid,
    input wire logic wdata_take,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid,
    input wire logic op_done,
    input wire logic cache_active,
    input wire nbc_pins_type pins,
    input wire logic [7:0] bus_in,
    input wire logic busy_flag_n
);
    // ****************
    // Pin relations
    // ****************
    wire cl = pins.command_latch_enable, al = pins.addr_latch_enable, ws = pins.wr_strobe_n, rs = pins.rd_strobe_n;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_WP_ON_PROG: assert property (
        cl && !ws && pins.bus_out inside {8'h80, 8'h60, 8'h10, 8'h15, 8'hd0, 8'h85} |-> pins.wp_n)
        else $error("write protect low at program or erase code");
    AST_READ_CYCLE: assert property (
        !rs |-> pins.bus_oe_n && !pins.chip_sel_n && ws && !cl && !al) else $error("bad read cycle");
    AST_CMD_CYCLE: assert property (cl |-> !al && rs && !pins.chip_sel_n) else $error("bad command cycle");
    AST_ADDR_CYCLE: assert property (al |-> !cl && rs && !pins.chip_sel_n) else $error("bad address cycle");
    AST_IDLE: assert property (req_ready |-> pins.chip_sel_n && pins.bus_oe_n) else $error("not in standby");
    AST_WR_PULSE: assert property ($fell(ws) |=> !ws [*3] ##1 ws) else $error("write pulse length");
    AST_RD_PULSE: assert property ($fell(rs) |=> !rs [*5] ##1 rs) else $error("read pulse length");
    AST_TAKE: assert property (
        wdata_take |-> !ws && !pins.bus_oe_n && !cl && !al && pins.bus_out == $past(wdata))
        else $error("data byte not on bus");
    cover property (rdata_valid);
    cover property (wdata_take);
    cover property ($rose(busy_flag_n));
endmodule // nbc_host_monitor

bind nbc_host nbc_host_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .wdata(wdata), .wdata_valid(wdata_valid), .wdata_take(wdata_take), .rdata(rdata),
    .rdata_valid(rdata_valid), .op_done(op_done), .cache_active(cache_active), .pins(pins), .bus_in(bus_in),
    .busy_flag_n(busy_flag_n));

// file: nbc_flash_model.sv
// Behavioural NAND memory answering the controller pins
`timescale 1ns/1ps
module nbc_flash_model
    import nbc_pkg::*;
#(
    parameter int BUSY_CYC = 40,
    parameter logic [7:0] STATUS_VAL = 8'he0
) (
    input wire logic sys_clk,
    input wire nbc_pins_type pins,
    output logic [7:0] bus_in,
    output logic busy_flag_n
);
    logic [7:0] arr [16];
    logic [7:0] wbuf [16];
    logic [7:0] addr [5];
    logic [7:0] cmd_r = 8'h00;
    logic [3:0] ptr_r = 4'h0;
    logic [2:0] acnt_r = 3'h0;
    logic wr_q = 1'b1, rd_q = 1'b1;
    int busy_r = 0;
    initial begin
        bus_in = 8'h00;
        foreach (arr[i]) arr[i] = 8'hff;
        foreach (wbuf[i]) wbuf[i] = 8'hff;
    end
    assign busy_flag_n = (busy_r == 0);
    // Strobe edge decode, commands taken even while busy
    always @(posedge sys_clk) begin
        wr_q <= pins.wr_strobe_n;
        rd_q <= pins.rd_strobe_n;
        if (busy_r > 0) busy_r <= busy_r - 1;
        if (pins.wr_strobe_n && !wr_q && !pins.chip_sel_n) begin
            if (pins.command_latch_enable) begin
                cmd_r <= pins.bus_out;
                acnt_r <= 3'h0;
                if (pins.bus_out == CMD_READ_GO) busy_r <= BUSY_CYC;
                if (pins.bus_out == CMD_PROG_GO && pins.wp_n) begin
                    arr <= wbuf;
                    busy_r <= BUSY_CYC;
                end
                if (pins.bus_out == CMD_ERASE_GO && pins.wp_n) begin
                    foreach (arr[i]) arr[i] <= 8'hff;
                    busy_r <= BUSY_CYC;
                end
            end else if (pins.addr_latch_enable) begin
                if (acnt_r < 3'h5) begin
                    addr[acnt_r] <= pins.bus_out;
                    acnt_r <= acnt_r + 3'h1;
                end
                if (acnt_r == 3'h0) ptr_r <= pins.bus_out[3:0];
            end else begin
                wbuf[ptr_r] <= pins.bus_out;
                ptr_r <= ptr_r + 4'h1;
            end
        end
        // Drive only in a read cycle, else a changing pattern
        if (!pins.chip_sel_n && pins.wr_strobe_n && !pins.command_latch_enable && !pins.addr_latch_enable
            && !pins.rd_strobe_n) begin
            if (rd_q) begin
                bus_in <= (cmd_r == CMD_STATUS) ? STATUS_VAL : arr[ptr_r];
                ptr_r <= ptr_r + 4'h1;
            end
        end
        else bus_in <= ~bus_in;
    end
endmodule // nbc_flash_model

// file: tb_nbc_host.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
module tb_nbc_host;
    import nbc_pkg::*;
    logic sys_clk, rst_n, req_valid, wdata_valid, busy_flag_n;
    logic req_ready, wdata_take, rdata_valid, op_done, cache_active;
    logic [7:0] wdata, bus_in, rdata;
    nbc_req_type req;
    nbc_pins_type pins;
    logic [7:0] wq [$];
    logic [7:0] rq [$];
    int n_mismatch = 0, checks = 0, cyc = 0;
    nbc_host dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .wdata(wdata), .wdata_valid(wdata_valid), .wdata_take(wdata_take), .rdata(rdata), .rdata_valid(rdata_valid),
        .op_done(op_done), .cache_active(cache_active), .pins(pins), .bus_in(bus_in), .busy_flag_n(busy_flag_n));
    nbc_flash_model #(.STATUS_VAL(8'he0)) flash (.sys_clk(sys_clk), .pins(pins), .bus_in(bus_in),
        .busy_flag_n(busy_flag_n));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Collect read bytes, feed write bytes, cut hangs
    always @(posedge sys_clk) begin
        if (rdata_valid === 1'b1) rq.push_back(rdata);
        #1;
        if (wdata_take === 1'b1) wq.delete(0);
        wdata_valid = wq.size() > 0;
        wdata = wdata_valid ? wq[0] : 8'h00;
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_req(input nbc_op_type op, input logic [11:0] col, input logic [11:0] len);
        int t;
        req = '{op, 1'b0, col, 6'h2, 13'h1005, len};
        rq.delete();
        t = 0;
        while (req_ready !== 1'b1 && t < 3000) begin
            @(posedge sys_clk);
            #1 t++;
        end
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1 req_valid = 1'b0;
        t = 0;
        while (op_done !== 1'b1 && t < 5000) begin
            @(posedge sys_clk);
            #1 t++;
        end
        check("op_done", op_done, 1);
    endtask
    task automatic test_status();
        check("idle cs", pins.chip_sel_n, 1);
        do_req(OP_STATUS, 12'h000, 12'h001);
        check("status", rq[0], 8'he0);
    endtask
    task automatic test_program();
        logic [7:0] ea [5] = '{8'h04, 8'h00, 8'h42, 8'h01, 8'h00};
        wq = '{8'ha1, 8'hb2, 8'hc3};
        do_req(OP_PROGRAM, 12'h004, 12'h003);
        foreach (ea[i]) check("addr byte", flash.addr[i], ea[i]);
        check("prog byte", flash.arr[6], 8'hc3);
        check("prog byte", flash.arr[4], 8'ha1);
    endtask
    task automatic test_read(input logic [7:0] e0, input logic [7:0] e1);
        do_req(OP_READ, 12'h004, 12'h002);
        check("read count", rq.size(), 2);
        check("read 0", rq[0], e0);
        check("read 1", rq[1], e1);
    endtask
    task automatic test_cache();
        do_req(OP_CACHE_READ, 12'h000, 12'h001);
        check("cache on", cache_active, 1);
        check("cache byte", rq[0], 8'hff);
        do_req(OP_EXIT_CACHE, 12'h000, 12'h000);
        check("exit code", flash.cmd_r, 8'h34);
        check("cache off", cache_active, 0);
    endtask
    task automatic test_erase();
        do_req(OP_ERASE, 12'h000, 12'h000);
        check("erase", flash.arr[5], 8'hff);
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wdata = 8'h00;
        wdata_valid = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        test_status();
        test_program();
        test_read(8'ha1, 8'hb2);
        test_erase();
        test_read(8'hff, 8'hff);
        test_cache();
        summarize();
    end
endmodule // tb_nbc_host
